/* src/vrc_pkg.sv */
// Notes on behaviour
// [R1] buffer readout answers both 32-bit block and 64-bit multiplexed block reads
// [R2] plain readout: master reads header, then the announced count of data words
// [R3] no stop, no bus error: block read drains all; empty buffer gives invalid words
// [R4] no stop, bus error on: block read drains all; empty buffer raises bus error
// [R5] stop on, no bus error: one event, then only invalid words
// [R6] stop on, bus error on: read of one event ends in bus error after trailer
// [R7] event is header, at most 32 data words, trailer: 34 words at most
// [R8] master enables bus-error endings only if its processor handles them well
// [R9] chain accesses are reads only, broadcast accesses are writes only
// [R10] shared base is an 8-bit value on address bits 31..24, lower bits zero
// [R11] software sets head only on first board, tail only on last board
// [R12] chain reads answered only with block or multiplexed block modifiers
// [R13] chain reads reach only the event buffer at shared base plus buffer offsets
// [R14] token holder sends data, marks itself done at its trailer, then drops out
// [R15] done board asserts daisy output to pass token to the next board
// [R16] tail board holding token while done raises bus error to end readout
// [R17] 64-bit chain read acknowledges the address phase in its first cycle
// [R18] auto advance steps pointer at trailer; otherwise pointer returns to header
// [R19] master issues boards plus one chain reads of 34 words each
// [R20] interrupted chain read resumes at the board that held the token
// [R21] one broadcast write updates the register on every board at once
// [R22] software never writes the shared base register by broadcast
// [R23] board without the token leaves data and acknowledge undriven
package vrc_pkg;
	// apb register offsets
	localparam logic [7:0]  APB_OFF_CTRL       = 8'h00;
	localparam logic [7:0]  APB_OFF_CHAIN_BASE = 8'h04;
	localparam logic [7:0]  APB_OFF_BOARD_BASE = 8'h08;
	localparam logic [7:0]  APB_OFF_STATUS     = 8'h0c;
	// vme-side offsets below a base
	localparam logic [23:0] VME_OFF_CTRL       = 24'h00_1010;
	localparam logic [23:0] VME_OFF_CHAIN_BASE = 24'h00_1004;
	localparam logic [11:0] VME_BUF_PAGE       = 12'h000;
	// control field positions
	localparam int CTRL_BLOCK_END = 0;
	localparam int CTRL_BERR_EN   = 1;
	localparam int CTRL_AUTO_ADV  = 2;
	localparam int CTRL_HEAD      = 3;
	localparam int CTRL_TAIL      = 4;
	localparam int CTRL_DONE_CLR  = 8;
	// status field positions
	localparam int STAT_DONE   = 0;
	localparam int STAT_EMPTY  = 1;
	localparam int STAT_EVT_LO = 8;
	// reset values
	localparam logic [7:0]  CHAIN_BASE_RST = 8'haa;
	localparam logic [7:0]  BOARD_BASE_RST = 8'h00;
	// address modifiers
	localparam logic [5:0]  AM_BLT32  = 6'h0f;
	localparam logic [5:0]  AM_MBLT64 = 6'h08;
	// buffer shape and word codes
	localparam logic [5:0]  MAX_EVENTS    = 6'h20;
	localparam logic [5:0]  MAX_EVT_WORDS = 6'h22;
	localparam logic [31:0] NOT_VALID     = 32'h0600_0000;
	typedef enum logic [0:0] {
		st_idle   = 1'b0,
		st_answer = 1'b1
	} vrc_state_e;
endpackage

/* src/vrc_sync.sv */
`timescale 1ns/1ps
// three-stage sampler; output moves once stages two and three agree
module vrc_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic o_ff;
			logic nxt_o;
			// hold last agreed value while stages disagree
			always_comb
			begin
				nxt_o = (s2_ff == s3_ff) ? s3_ff : o_ff;
			end
			always_ff @(posedge clk)
			begin
				if (!rstn)
				begin
					s1_ff <= RST[i];
					s2_ff <= RST[i];
					s3_ff <= RST[i];
					o_ff  <= RST[i];
				end
				else
				begin
					s1_ff <= din[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					o_ff  <= nxt_o;
				end
			end
			assign dout[i] = o_ff;
		end
	endgenerate
endmodule

/* src/vrc_top.sv */
`timescale 1ns/1ps
module vrc_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// event words from acquisition
	input  wire logic        evt_valid,
	input  wire logic [31:0] evt_data,
	input  wire logic        evt_last,
	output logic             evt_ready,
	// vme pins
	input  wire logic        vme_as_n,
	input  wire logic        vme_ds_n,
	input  wire logic        vme_write_n,
	input  wire logic [5:0]  vme_am,
	input  wire logic [31:0] vme_addr,
	input  wire logic [31:0] vme_data_i,
	output logic      [63:0] vme_data_o,
	output logic             vme_data_oe,
	output logic             vme_dtack_n_o,
	output logic             vme_dtack_oe,
	output logic             vme_berr_n_o,
	output logic             vme_berr_oe,
	input  wire logic        vme_iack_in_n,
	output logic             vme_iack_out_n
);
	////////////////////////////////////////////////////////////////////////////////
	// base match on the top byte only, lower base bits are zero
	function automatic logic base_hit(input logic [31:0] a, input logic [7:0] b);
		base_hit = (a[31:24] == b); // R10
	endfunction

	logic [3:0]  syn;
	logic        as_s;
	logic        ds_s;
	logic        wr_s;
	logic        iack_s;
	vrc_sync #(.W(4), .RST(4'hf)) i_vrc_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({vme_as_n, vme_ds_n, vme_write_n, vme_iack_in_n}),
		.dout (syn)
	);
	assign {as_s, ds_s, wr_s, iack_s} = syn;

	logic [32:0]        mem [0:2047];
	vrc_pkg::vrc_state_e st_ff,         nxt_st;
	logic               blk_end_ff,    nxt_blk_end;
	logic               berr_en_ff,    nxt_berr_en;
	logic               auto_ff,       nxt_auto;
	logic               head_ff,       nxt_head;
	logic               tail_ff,       nxt_tail;
	logic               done_ff,       nxt_done;
	logic [7:0]         chain_base_ff, nxt_chain_base;
	logic [7:0]         board_base_ff, nxt_board_base;
	logic [10:0]        rd_ptr_ff,     nxt_rd_ptr;
	logic [10:0]        wr_ptr_ff,     nxt_wr_ptr;
	logic [10:0]        ev_start_ff,   nxt_ev_start;
	logic [5:0]         events_ff,     nxt_events;
	logic [5:0]         cur_len_ff,    nxt_cur_len;
	logic               stop_ff,       nxt_stop;
	logic               addr_ack_ff,   nxt_addr_ack;
	logic               dtack_ff,      nxt_dtack;
	logic               berr_ff,       nxt_berr;
	logic               doe_ff,        nxt_doe;
	logic [63:0]        data_ff,       nxt_data;
	logic               iack_n_ff,     nxt_iack_n;

	////////////////////////////////////////////////////////////////////////////////
	// decode of the cycle in progress
	logic        go;
	logic        token;
	logic        chain_hit;
	logic        board_hit;
	logic        is_buf;
	logic        is_blt;
	logic        mblt;
	logic        c_rd;
	logic        b_rd;
	logic        empty;
	logic [32:0] w0;
	logic [32:0] w1;
	logic        trl;
	logic [1:0]  step;
	logic [63:0] rd_word;
	logic        wr_take;
	logic        wr_trl;
	logic        apb_wr;

	assign go        = (st_ff == vrc_pkg::st_idle) && !as_s && !ds_s;
	assign token     = head_ff || !iack_s;
	assign chain_hit = base_hit(vme_addr, chain_base_ff);
	assign board_hit = base_hit(vme_addr, board_base_ff);
	assign is_buf    = (vme_addr[23:12] == vrc_pkg::VME_BUF_PAGE); // R13
	assign is_blt    = (vme_am == vrc_pkg::AM_BLT32) || (vme_am == vrc_pkg::AM_MBLT64); // R12
	assign mblt      = (vme_am == vrc_pkg::AM_MBLT64);
	assign c_rd      = go && wr_s && chain_hit && is_buf && is_blt; // R9
	assign b_rd      = go && wr_s && !chain_hit && board_hit && is_buf;
	assign empty     = (events_ff == 6'h00);
	assign w0        = mem[rd_ptr_ff];
	assign w1        = mem[rd_ptr_ff + 11'h001];
	// 64-bit beat pairs two words, low word first; a trailer in the low half ends it
	assign trl       = w0[32] || (mblt && w1[32]);
	assign step      = (mblt && !w0[32]) ? 2'h2 : 2'h1;
	assign rd_word   = !mblt ? {32'h0000_0000, w0[31:0]} :
	                   w0[32] ? {vrc_pkg::NOT_VALID, w0[31:0]} : {w1[31:0], w0[31:0]}; // R1
	assign evt_ready = (events_ff < vrc_pkg::MAX_EVENTS);
	assign wr_take   = evt_valid && evt_ready;
	// the 34th word is forced to close the event
	assign wr_trl    = evt_last || (cur_len_ff == vrc_pkg::MAX_EVT_WORDS - 6'h01); // R7
	assign apb_wr    = psel && penable && pwrite;

	////////////////////////////////////////////////////////////////////////////////
	// apb answers at once, never waits
	always_comb
	begin
		pready  = 1'b1;
		pslverr = 1'b0;
		prdata  = 32'h0000_0000;
		case (paddr)
			vrc_pkg::APB_OFF_CTRL:
				prdata = {27'h000_0000, tail_ff, head_ff, auto_ff, berr_en_ff, blk_end_ff};
			vrc_pkg::APB_OFF_CHAIN_BASE: prdata = {24'h00_0000, chain_base_ff};
			vrc_pkg::APB_OFF_BOARD_BASE: prdata = {24'h00_0000, board_base_ff};
			vrc_pkg::APB_OFF_STATUS:
				prdata = {18'h0_0000, events_ff, 6'h00, empty, done_ff};
			default: pslverr = psel && penable;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// buffer fill, written only by acquisition side
	always_ff @(posedge clk)
	begin
		if (wr_take)
			mem[wr_ptr_ff] <= {wr_trl, evt_data};
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state of bus slave, config and pointers
	always_comb
	begin
		nxt_st         = st_ff;
		nxt_blk_end    = blk_end_ff;
		nxt_berr_en    = berr_en_ff;
		nxt_auto       = auto_ff;
		nxt_head       = head_ff;
		nxt_tail       = tail_ff;
		nxt_done       = done_ff;
		nxt_chain_base = chain_base_ff;
		nxt_board_base = board_base_ff;
		nxt_rd_ptr     = rd_ptr_ff;
		nxt_wr_ptr     = wr_ptr_ff;
		nxt_ev_start   = ev_start_ff;
		nxt_events     = events_ff;
		nxt_cur_len    = cur_len_ff;
		nxt_stop       = stop_ff;
		nxt_addr_ack   = addr_ack_ff;
		nxt_dtack      = dtack_ff;
		nxt_berr       = berr_ff;
		nxt_doe        = doe_ff;
		nxt_data       = data_ff;
		// per-block flags live only while the address strobe is held
		if (as_s)
		begin
			nxt_stop     = 1'b0;
			nxt_addr_ack = 1'b0;
		end
		// apb first, so a same-cycle done event below still wins
		if (apb_wr && paddr == vrc_pkg::APB_OFF_CTRL)
		begin
			nxt_blk_end = pwdata[vrc_pkg::CTRL_BLOCK_END];
			nxt_berr_en = pwdata[vrc_pkg::CTRL_BERR_EN];
			nxt_auto    = pwdata[vrc_pkg::CTRL_AUTO_ADV];
			nxt_head    = pwdata[vrc_pkg::CTRL_HEAD];
			nxt_tail    = pwdata[vrc_pkg::CTRL_TAIL];
			if (pwdata[vrc_pkg::CTRL_DONE_CLR])
				nxt_done = 1'b0;
		end
		if (apb_wr && paddr == vrc_pkg::APB_OFF_CHAIN_BASE)
			nxt_chain_base = pwdata[7:0];
		if (apb_wr && paddr == vrc_pkg::APB_OFF_BOARD_BASE)
			nxt_board_base = pwdata[7:0];
		case (st_ff)
			vrc_pkg::st_idle:
			begin
				if (go && !wr_s && (chain_hit || board_hit)
					&& vme_addr[23:0] == vrc_pkg::VME_OFF_CTRL)
				begin
					// broadcast or own write, every board acks the same strobe
					nxt_blk_end = vme_data_i[vrc_pkg::CTRL_BLOCK_END]; // R21
					nxt_berr_en = vme_data_i[vrc_pkg::CTRL_BERR_EN];
					nxt_auto    = vme_data_i[vrc_pkg::CTRL_AUTO_ADV];
					nxt_head    = vme_data_i[vrc_pkg::CTRL_HEAD];
					nxt_tail    = vme_data_i[vrc_pkg::CTRL_TAIL];
					nxt_dtack   = 1'b1;
					nxt_st      = vrc_pkg::st_answer;
				end
				else if (go && !wr_s && !chain_hit && board_hit
					&& vme_addr[23:0] == vrc_pkg::VME_OFF_CHAIN_BASE)
				begin
					// shared base only by the board's own address, not by broadcast
					nxt_chain_base = vme_data_i[7:0];
					nxt_dtack      = 1'b1;
					nxt_st         = vrc_pkg::st_answer;
				end
				else if (c_rd && token) // R23
				begin
					if (done_ff)
					begin
						// a done non-tail board stays silent, the next board answers
						if (tail_ff)
						begin
							nxt_berr = 1'b1; // R16
							nxt_st   = vrc_pkg::st_answer;
						end
					end
					else if (mblt && !addr_ack_ff)
					begin
						nxt_addr_ack = 1'b1; // R17
						nxt_dtack    = 1'b1;
						nxt_st       = vrc_pkg::st_answer;
					end
					else if (empty)
						nxt_done = 1'b1; // R14
					else
					begin
						nxt_data   = rd_word;
						nxt_doe    = 1'b1;
						nxt_dtack  = 1'b1;
						nxt_st     = vrc_pkg::st_answer;
						nxt_rd_ptr = rd_ptr_ff + 11'(step);
						if (trl)
							nxt_done = 1'b1; // R14
					end
				end
				else if (b_rd)
				begin
					nxt_st = vrc_pkg::st_answer;
					if (stop_ff || empty)
					begin
						// stop only follows a trailer when block-end is set
						if (berr_en_ff)
							nxt_berr = 1'b1; // R4 R6
						else
						begin
							nxt_data  = {vrc_pkg::NOT_VALID, vrc_pkg::NOT_VALID}; // R3 R5
							nxt_doe   = 1'b1;
							nxt_dtack = 1'b1;
						end
					end
					else
					begin
						nxt_data   = rd_word; // R1
						nxt_doe    = 1'b1;
						nxt_dtack  = 1'b1;
						nxt_rd_ptr = rd_ptr_ff + 11'(step);
						if (trl && blk_end_ff)
							nxt_stop = 1'b1; // R5 R6
					end
				end
			end
			vrc_pkg::st_answer:
			begin
				// hold the answer until the master lifts its data strobe
				if (ds_s)
				begin
					nxt_dtack = 1'b0;
					nxt_berr  = 1'b0;
					nxt_doe   = 1'b0;
					nxt_st    = vrc_pkg::st_idle;
				end
			end
			default: nxt_st = vrc_pkg::st_idle;
		endcase
		// trailer consumed: advance to next event or fall back to its header
		if (nxt_rd_ptr != rd_ptr_ff && trl)
		begin
			if (auto_ff)
				nxt_ev_start = nxt_rd_ptr; // R18
			else
				nxt_rd_ptr = ev_start_ff; // R18
		end
		// event count: a fill and a drain in one cycle cancel out
		nxt_events = events_ff
			+ ((wr_take && wr_trl) ? 6'h01 : 6'h00)
			- ((nxt_ev_start != ev_start_ff) ? 6'h01 : 6'h00);
		if (wr_take)
		begin
			nxt_wr_ptr  = wr_ptr_ff + 11'h001;
			nxt_cur_len = wr_trl ? 6'h00 : cur_len_ff + 6'h01;
		end
	end

	// done board passes the token; done survives bus timeouts so the chain resumes
	assign nxt_iack_n = !(nxt_done && token); // R15 R20

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_ff         <= vrc_pkg::st_idle;
			blk_end_ff    <= 1'b0;
			berr_en_ff    <= 1'b0;
			auto_ff       <= 1'b0;
			head_ff       <= 1'b0;
			tail_ff       <= 1'b0;
			done_ff       <= 1'b0;
			chain_base_ff <= vrc_pkg::CHAIN_BASE_RST;
			board_base_ff <= vrc_pkg::BOARD_BASE_RST;
			rd_ptr_ff     <= 11'h000;
			wr_ptr_ff     <= 11'h000;
			ev_start_ff   <= 11'h000;
			events_ff     <= 6'h00;
			cur_len_ff    <= 6'h00;
			stop_ff       <= 1'b0;
			addr_ack_ff   <= 1'b0;
			dtack_ff      <= 1'b0;
			berr_ff       <= 1'b0;
			doe_ff        <= 1'b0;
			data_ff       <= 64'h0000_0000_0000_0000;
			iack_n_ff     <= 1'b1;
		end
		else
		begin
			st_ff         <= nxt_st;
			blk_end_ff    <= nxt_blk_end;
			berr_en_ff    <= nxt_berr_en;
			auto_ff       <= nxt_auto;
			head_ff       <= nxt_head;
			tail_ff       <= nxt_tail;
			done_ff       <= nxt_done;
			chain_base_ff <= nxt_chain_base;
			board_base_ff <= nxt_board_base;
			rd_ptr_ff     <= nxt_rd_ptr;
			wr_ptr_ff     <= nxt_wr_ptr;
			ev_start_ff   <= nxt_ev_start;
			events_ff     <= nxt_events;
			cur_len_ff    <= nxt_cur_len;
			stop_ff       <= nxt_stop;
			addr_ack_ff   <= nxt_addr_ack;
			dtack_ff      <= nxt_dtack;
			berr_ff       <= nxt_berr;
			doe_ff        <= nxt_doe;
			data_ff       <= nxt_data;
			iack_n_ff     <= nxt_iack_n;
		end
	end

	// open-drain lines only ever pull low
	assign vme_data_o     = data_ff;
	assign vme_data_oe    = doe_ff;
	assign vme_dtack_n_o  = 1'b0;
	assign vme_dtack_oe   = dtack_ff;
	assign vme_berr_n_o   = 1'b0;
	assign vme_berr_oe    = berr_ff;
	assign vme_iack_out_n = iack_n_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks on the answers
	no_token_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // R23
		(c_rd && !token && !dtack_ff) |=> !vme_dtack_oe && !vme_data_oe)
		else $error("board without token drove the bus");
	tail_end_berr_a: assert property (@(posedge clk) disable iff (!rstn) // R16
		(c_rd && token && done_ff && tail_ff) |=> vme_berr_oe && !vme_dtack_oe)
		else $error("tail board missed its ending bus error");
	done_pass_a: assert property (@(posedge clk) disable iff (!rstn) // R15
		(done_ff && token) |=> ##1 (!vme_iack_out_n || !$past(token) || !done_ff))
		else $error("done board kept the token");
	trailer_done_a: assert property (@(posedge clk) disable iff (!rstn) // R14
		(c_rd && token && !done_ff && !empty && trl && (addr_ack_ff || !mblt))
		|=> done_ff && vme_data_oe)
		else $error("trailer did not mark board done");
	empty_berr_a: assert property (@(posedge clk) disable iff (!rstn) // R4
		(b_rd && empty && berr_en_ff) |=> vme_berr_oe && !vme_data_oe)
		else $error("empty buffer gave no bus error");
	empty_nv_a: assert property (@(posedge clk) disable iff (!rstn) // R3
		(b_rd && (empty || stop_ff) && !berr_en_ff)
		|=> vme_dtack_oe && vme_data_o[31:0] == vrc_pkg::NOT_VALID)
		else $error("expected an invalid word");
	stop_after_a: assert property (@(posedge clk) disable iff (!rstn) // R5
		(b_rd && !empty && !stop_ff && trl && blk_end_ff) |=> stop_ff ##1 vme_dtack_oe)
		else $error("block end did not stop after trailer");
	mblt_addr_a: assert property (@(posedge clk) disable iff (!rstn) // R17
		(c_rd && token && !done_ff && mblt && !addr_ack_ff)
		|=> vme_dtack_oe && !vme_data_oe && $stable(rd_ptr_ff))
		else $error("address phase not acknowledged alone");
	no_adv_a: assert property (@(posedge clk) disable iff (!rstn) // R18
		((c_rd && token && !done_ff && (addr_ack_ff || !mblt)) || (b_rd && !stop_ff))
		&& !empty && trl && !auto_ff
		|=> rd_ptr_ff == $past(ev_start_ff) && events_ff == $past(events_ff))
		else $error("pointer moved with auto advance off");
	bcast_write_a: assert property (@(posedge clk) disable iff (!rstn) // R9
		(go && !wr_s && chain_hit && is_buf) |=> !vme_dtack_oe && $stable(rd_ptr_ff))
		else $error("chain buffer write was answered");
endmodule

/* test/vrc_vme_master.sv */
`timescale 1ns/1ps
// bus master model: one address cycle carries any number of data strobes
module vrc_vme_master (
	input  wire logic        clk,
	output logic             as_n,
	output logic             ds_n,
	output logic             write_n,
	output logic [5:0]       am,
	output logic [31:0]      addr,
	output logic [31:0]      data_o,
	input  wire logic [63:0] data_i,
	input  wire logic        data_oe,
	input  wire logic        dtack_n,
	input  wire logic        berr_n
);
	logic [31:0] last_wd;
	logic        oe_seen;
	initial
	begin
		{as_n, ds_n, write_n} = 3'b111;
		am = 6'h00;
		addr = 32'h0000_0000;
		last_wd = 32'h0000_0000;
		data_o = 32'hffff_ffff;
		oe_seen = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// address phase; lines stay put until close_cyc
	task automatic open_cyc(input logic [5:0] m, input logic [31:0] a, input logic w);
		@(posedge clk);
		am <= m;
		addr <= a;
		write_n <= ~w;
		as_n <= 1'b0;
	endtask
	// resp 0 dtack, 1 bus error, 2 nothing; strobe held until answer seen or 20 cycles pass
	task automatic beat(input logic [31:0] wd, output logic [63:0] rd, output logic [1:0] resp);
		int n;
		n = 0;
		resp = 2'd2;
		rd = '0;
		@(posedge clk);
		if (!write_n)
			last_wd = wd;
		data_o <= write_n ? ~last_wd : wd;
		ds_n <= 1'b0;
		while (resp == 2'd2 && n < 20)
		begin
			@(posedge clk);
			n++;
			if (data_oe === 1'b1)
				oe_seen = 1'b1;
			if (dtack_n === 1'b0 || berr_n === 1'b0)
			begin
				resp = (dtack_n === 1'b0) ? 2'd0 : 2'd1;
				rd = (data_oe === 1'b1) ? data_i : ~data_i;
			end
		end
		// released data lines must not keep the old value
		ds_n <= 1'b1;
		data_o <= ~last_wd;
		n = 0;
		while ((dtack_n & berr_n) !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	// strobe lines are synchronised, so give the release time to land
	task automatic close_cyc();
		@(posedge clk);
		as_n <= 1'b1;
		write_n <= 1'b1;
		addr <= ~addr;
		repeat (6) @(posedge clk);
	endtask
endmodule

/* test/vrc_top_tb.sv */
`timescale 1ns/1ps
module vrc_top_tb;
	localparam logic [31:0] CHN = 32'haa00_0000;
	localparam logic [31:0] C_END = 32'h0000_0001 << vrc_pkg::CTRL_BLOCK_END;
	localparam logic [31:0] C_BE = 32'h0000_0001 << vrc_pkg::CTRL_BERR_EN;
	localparam logic [31:0] C_AUTO = 32'h0000_0001 << vrc_pkg::CTRL_AUTO_ADV;
	localparam logic [31:0] C_HT = 32'h0000_0018;
	localparam logic [31:0] C_CLR = 32'h0000_0001 << vrc_pkg::CTRL_DONE_CLR;
	localparam logic [63:0] NV = {32'h0, vrc_pkg::NOT_VALID};
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, evt_data, vaddr, vwd, rdv;
	logic        evt_valid, evt_last, evt_ready, as_n, ds_n, wr_n, iack_in_n, iack_out_n;
	logic [5:0]  am;
	logic [63:0] vrd, got;
	logic        d_oe, dt_oe, dt_o, be_oe, be_o, er;
	logic [1:0]  r;
	wire         dtack_n = dt_oe ? dt_o : 1'b1;
	wire         berr_n = be_oe ? be_o : 1'b1;
	int          fails, checks_done, cycles;
	vrc_top i_vrc_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .evt_valid(evt_valid), .evt_data(evt_data),
		.evt_last(evt_last), .evt_ready(evt_ready), .vme_as_n(as_n), .vme_ds_n(ds_n),
		.vme_write_n(wr_n), .vme_am(am), .vme_addr(vaddr), .vme_data_i(vwd),
		.vme_data_o(vrd), .vme_data_oe(d_oe), .vme_dtack_n_o(dt_o), .vme_dtack_oe(dt_oe),
		.vme_berr_n_o(be_o), .vme_berr_oe(be_oe), .vme_iack_in_n(iack_in_n),
		.vme_iack_out_n(iack_out_n));
	vrc_vme_master i_vrc_vme_master (.clk(clk), .as_n(as_n), .ds_n(ds_n), .write_n(wr_n),
		.am(am), .addr(vaddr), .data_o(vwd), .data_i(vrd), .data_oe(d_oe),
		.dtack_n(dtack_n), .berr_n(berr_n));
	////////////////////////////////////////////////////////////////////////
	// compare helpers: one for values, one for bus answers
	task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %0d seen %0d", what, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// apb transfer held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdv = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// event word: tag byte over word index, so every word is unique
	function automatic logic [31:0] wv(input logic [7:0] k, input int i);
		return {k, 24'(i)};
	endfunction
	task automatic push(input logic [7:0] k, input int nd);
		@(posedge clk);
		for (int i = 0; i <= nd + 1; i++)
		begin
			{evt_valid, evt_data, evt_last} <= {1'b1, wv(k, i), i == nd + 1};
			@(posedge clk);
			while (evt_ready !== 1'b1)
				@(posedge clk);
		end
		evt_valid <= 1'b0;
	endtask
	// mode 0 ignores data, 1 low word only, 2 whole beat
	task automatic strobe(input logic [31:0] wd, input logic [1:0] e, input logic [63:0] ew,
			input logic [1:0] mode);
		i_vrc_vme_master.beat(wd, got, r);
		chk_resp("vme answer", e, r);
		if (mode != 2'd0)
			chk("vme data", ew, mode == 2'd1 ? {32'h0, got[31:0]} : got);
	endtask
	task automatic rd_words(input logic [7:0] k, input int a, input int b);
		for (int i = a; i <= b; i++)
			strobe(0, 2'd0, {32'h0, wv(k, i)}, 2'd1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_block();
		apb(0, vrc_pkg::APB_OFF_CHAIN_BASE, 0);
		chk("chain base", 64'haa, rdv);
		apb(0, 8'h40, 0);
		chk("unmapped error", 64'h1, er);
		apb(1, 8'h00, C_AUTO);
		push(8'ha1, 2);
		push(8'ha2, 0);
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, 32'h0000_0000, 0);
		rd_words(8'ha1, 0, 3);
		rd_words(8'ha2, 0, 1);
		strobe(0, 2'd0, NV, 2'd1);
		// auto advance off: the trailer sends the pointer back to the header
		apb(1, 8'h00, 0);
		push(8'ha3, 0);
		rd_words(8'ha3, 0, 1);
		rd_words(8'ha3, 0, 1);
		apb(1, 8'h00, C_AUTO | C_BE);
		rd_words(8'ha3, 0, 1);
		strobe(0, 2'd1, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		$display("block drain done");
	endtask
	task automatic t_stop();
		apb(1, 8'h00, C_AUTO | C_END);
		push(8'hc1, 1);
		push(8'hc2, 1);
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, 32'h0000_0000, 0);
		rd_words(8'hc1, 0, 2);
		strobe(0, 2'd0, NV, 2'd1);
		i_vrc_vme_master.close_cyc();
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, 32'h0000_0000, 0);
		rd_words(8'hc2, 0, 2);
		i_vrc_vme_master.close_cyc();
		apb(1, 8'h00, C_AUTO | C_END | C_BE);
		push(8'hc3, 32);
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, 32'h0000_0000, 0);
		rd_words(8'hc3, 0, 33);
		strobe(0, 2'd1, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		apb(1, 8'h00, C_AUTO);
		push(8'hd1, 2);
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_MBLT64, 32'h0000_0000, 0);
		strobe(0, 2'd0, {wv(8'hd1, 1), wv(8'hd1, 0)}, 2'd2);
		strobe(0, 2'd0, {wv(8'hd1, 3), wv(8'hd1, 2)}, 2'd2);
		i_vrc_vme_master.close_cyc();
		$display("stop and wide done");
	endtask
	task automatic t_chain();
		apb(1, 8'h00, C_AUTO | C_HT);
		push(8'he1, 2);
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, CHN, 0);
		rd_words(8'he1, 0, 1);
		i_vrc_vme_master.close_cyc();
		chk("token out", 64'h1, iack_out_n);
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, CHN, 0);
		rd_words(8'he1, 2, 3);
		strobe(0, 2'd1, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		chk("token out", 64'h0, iack_out_n);
		apb(0, vrc_pkg::APB_OFF_STATUS, 0);
		chk("done flag", 64'h1, rdv[vrc_pkg::STAT_DONE]);
		apb(1, 8'h00, C_AUTO | C_HT | C_CLR);
		push(8'he2, 1);
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_MBLT64, CHN, 0);
		strobe(0, 2'd0, 0, 2'd0);
		strobe(0, 2'd0, {wv(8'he2, 1), wv(8'he2, 0)}, 2'd2);
		strobe(0, 2'd0, {NV[31:0], wv(8'he2, 2)}, 2'd2);
		strobe(0, 2'd1, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		$display("chain done");
	endtask
	task automatic t_refuse();
		apb(1, 8'h00, C_AUTO | C_CLR);
		push(8'hf1, 0);
		i_vrc_vme_master.oe_seen = 1'b0;
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, CHN, 0);
		strobe(0, 2'd2, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		chk("data drive", 64'h0, i_vrc_vme_master.oe_seen);
		iack_in_n <= 1'b0;
		i_vrc_vme_master.open_cyc(6'h09, CHN, 0);
		strobe(0, 2'd2, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, CHN, 1);
		strobe(32'h1234_5678, 2'd2, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		i_vrc_vme_master.open_cyc(vrc_pkg::AM_BLT32, CHN, 0);
		rd_words(8'hf1, 0, 1);
		i_vrc_vme_master.close_cyc();
		iack_in_n <= 1'b1;
		// broadcast touches control only, never the shared base
		i_vrc_vme_master.open_cyc(6'h09, CHN | {8'h0, vrc_pkg::VME_OFF_CTRL}, 1);
		strobe(C_AUTO | C_HT, 2'd0, 0, 2'd0);
		i_vrc_vme_master.close_cyc();
		apb(0, 8'h00, 0);
		chk("control", {32'h0, C_AUTO | C_HT}, rdv);
		$display("refusals and broadcast done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard: whole run needs well under this many cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fails++;
			report_and_stop();
		end
	end
	initial
	begin
		{rstn, psel, penable, pwrite, evt_valid, evt_last} = 6'b000000;
		{paddr, pwdata, evt_data} = '0;
		iack_in_n = 1'b1;
		{fails, checks_done, cycles} = '0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		t_block();
		t_stop();
		t_chain();
		t_refuse();
		report_and_stop();
	end
endmodule
